// *** src/sivr_pkg.sv ***
package sivr_pkg;

  localparam int          SIVR_NUM_REGS   = 4;
  localparam int          SIVR_NUM_SRC    = 8;
  localparam int          SIVR_DATA_W     = 16;
  localparam int          SIVR_VEC_W      = 7;
  localparam int          SIVR_ADDR_W     = 4;

  // Byte offsets of the 16-bit registers on the plain port
  localparam logic [3:0]  SIVR_OFS_FIFO_ERR  = 4'h0;
  localparam logic [3:0]  SIVR_OFS_FIFO_DATA = 4'h2;
  localparam logic [3:0]  SIVR_OFS_U1_ERR    = 4'h4;
  localparam logic [3:0]  SIVR_OFS_U1_DATA   = 4'h6;
  localparam logic [3:0]  SIVR_REG_OFFSET [SIVR_NUM_REGS] = '{
    SIVR_OFS_FIFO_ERR, SIVR_OFS_FIFO_DATA, SIVR_OFS_U1_ERR, SIVR_OFS_U1_DATA
  };

  localparam logic [15:0] SIVR_RESET_VALUE = 16'h0000;
  localparam logic [15:0] SIVR_WRITE_MASK  = 16'h7F7F;
  localparam logic [6:0]  SIVR_VEC_RESET   = 7'h00;
  localparam int          SIVR_HI_MSB      = 14;
  localparam int          SIVR_HI_LSB      = 8;
  localparam int          SIVR_LO_MSB      = 6;
  localparam int          SIVR_LO_LSB      = 0;
  localparam int          SIVR_RSVD_HI     = 15;
  localparam int          SIVR_RSVD_LO     = 7;

  // Source codes presented with an accepted interrupt
  typedef enum logic [2:0] {
    SIVR_SRC_FIFO_RX_OVERRUN  = 3'b000,
    SIVR_SRC_FIFO_TX_UNDERRUN = 3'b001,
    SIVR_SRC_FIFO_RX_FULL     = 3'b010,
    SIVR_SRC_FIFO_TX_EMPTY    = 3'b011,
    SIVR_SRC_U1_RX_OVERRUN    = 3'b100,
    SIVR_SRC_U1_TX_UNDERRUN   = 3'b101,
    SIVR_SRC_U1_RX_FULL       = 3'b110,
    SIVR_SRC_U1_TX_EMPTY      = 3'b111
  } sivr_src_type;

endpackage : sivr_pkg

// *** src/sivr_vec_reg.sv ***
`timescale 1ns/100ps
`default_nettype none
module sivr_vec_reg
  import sivr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  output logic      [15:0] value,
  output logic      [6:0]  hi_field,
  output logic      [6:0]  lo_field
);

  // Standby is not an input here: nothing but reset or a write moves it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_field <= SIVR_RESET_VALUE[SIVR_HI_MSB:SIVR_HI_LSB];
      lo_field <= SIVR_RESET_VALUE[SIVR_LO_MSB:SIVR_LO_LSB];
    end else if (wr_en) begin
      hi_field <= wdata[SIVR_HI_MSB:SIVR_HI_LSB];
      lo_field <= wdata[SIVR_LO_MSB:SIVR_LO_LSB];
    end
  end

  assign value = {1'b0, hi_field, 1'b0, lo_field};

endmodule : sivr_vec_reg
`default_nettype wire

// *** src/sivr_vec_sel.sv ***
`timescale 1ns/100ps
`default_nettype none
module sivr_vec_sel
  import sivr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         accept,
  input  wire sivr_src_type src,
  input  wire logic [55:0]  fields,
  output logic      [6:0]   vector,
  output logic              valid
);

  logic [6:0] next_vector;

  always_comb begin
    next_vector = fields[src*SIVR_VEC_W +: SIVR_VEC_W];
  end

  // Field read at acceptance, so a later rewrite does not disturb it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vector <= SIVR_VEC_RESET;
      valid  <= 1'b0;
    end else begin
      valid <= accept;
      if (accept) begin
        vector <= next_vector;
      end
    end
  end

endmodule : sivr_vec_sel
`default_nettype wire

// *** src/sivr_top.sv ***
// Notes on behaviour
// (R1) The four 16-bit registers are read/write apart from reserved bits.
// (R2) Reset clears every register to zero.
// (R3) Standby entry or exit leaves the register contents untouched.
// (R4) Bits 15 and 7 always read zero and writes to them are dropped.
// (R5) Software writes zero into bits 15 and 7.
// (R6) Each seven-bit field holds any vector 0 to 127 exactly as written.
// (R7) FIFO error register bits 14:8 hold the FIFO receive overrun vector.
// (R8) FIFO error register bits 6:0 hold the FIFO transmit underrun vector.
// (R9) FIFO data register bits 14:8 hold the FIFO unit receive full vector.
// (R10) FIFO data register bits 6:0 hold the FIFO unit transmit empty vector.
// (R11) Unit 1 error register bits 14:8 hold the unit 1 receive overrun vector.
// (R12) Unit 1 error register bits 6:0 hold its transmit underrun vector.
// (R13) Unit 1 data register bits 14:8 hold the unit 1 receive full vector.
// (R14) Unit 1 data register bits 6:0 hold the unit 1 transmit empty vector.
// (R15) An accepted source is answered with its current field as the vector.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sivr_top
  import sivr_pkg::*;
#(
  parameter int ADDR_W = SIVR_ADDR_W
)
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              standby,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [15:0]       rdata,
  output logic      [6:0]        fifo_rx_overrun_vector,
  output logic      [6:0]        fifo_tx_underrun_vector,
  output logic      [6:0]        fifo_rx_full_vector,
  output logic      [6:0]        fifo_tx_empty_vector,
  output logic      [6:0]        unit1_rx_overrun_vector,
  output logic      [6:0]        unit1_tx_underrun_vector,
  output logic      [6:0]        unit1_rx_full_vector,
  output logic      [6:0]        unit1_tx_empty_vector,
  input  wire logic              accept,
  input  wire sivr_src_type      accept_src,
  output logic      [6:0]        accept_vector,
  output logic                   accept_valid
);

  if (ADDR_W < SIVR_ADDR_W) begin : g_addr_check
    $error("sivr_top: ADDR_W too narrow for the register offsets");
  end

  logic [SIVR_NUM_REGS-1:0] hit;
  logic [15:0]              reg_value [SIVR_NUM_REGS];
  logic [6:0]               hi_field  [SIVR_NUM_REGS];
  logic [6:0]               lo_field  [SIVR_NUM_REGS];
  logic [55:0]              fields;
  logic [15:0]              next_rdata;

  // One register per generate entry; address decode is exact match
  for (genvar k = 0; k < SIVR_NUM_REGS; k++) begin : g_reg
    assign hit[k] = (addr == ADDR_W'(SIVR_REG_OFFSET[k]));

    sivr_vec_reg u_reg (
      .clk      (clk),
      .arst_n   (arst_n),
      .wr_en    (wr && hit[k]), // R1
      .wdata    (wdata),
      .value    (reg_value[k]),
      .hi_field (hi_field[k]),
      .lo_field (lo_field[k])
    );

    // Source 2k is the upper field, 2k+1 the lower one
    assign fields[(2*k)*SIVR_VEC_W +: SIVR_VEC_W]   = hi_field[k];
    assign fields[(2*k+1)*SIVR_VEC_W +: SIVR_VEC_W] = lo_field[k];
  end

  assign fifo_rx_overrun_vector   = hi_field[0]; // R7
  assign fifo_tx_underrun_vector  = lo_field[0]; // R8
  assign fifo_rx_full_vector      = hi_field[1]; // R9
  assign fifo_tx_empty_vector     = lo_field[1]; // R10
  assign unit1_rx_overrun_vector  = hi_field[2]; // R11
  assign unit1_tx_underrun_vector = lo_field[2]; // R12
  assign unit1_rx_full_vector     = hi_field[3]; // R13
  assign unit1_tx_empty_vector    = lo_field[3]; // R14

  // Unmapped offsets read as zero rather than aliasing
  always_comb begin
    next_rdata = SIVR_RESET_VALUE;
    for (int k = 0; k < SIVR_NUM_REGS; k++) begin
      if (hit[k]) begin
        next_rdata = reg_value[k] & SIVR_WRITE_MASK; // R4
      end
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= SIVR_RESET_VALUE;
    end else if (rd) begin
      rdata <= next_rdata; // R1
    end else begin
      rdata <= SIVR_RESET_VALUE;
    end
  end

  sivr_vec_sel u_sel (
    .clk    (clk),
    .arst_n (arst_n),
    .accept (accept),
    .src    (accept_src),
    .fields (fields),
    .vector (accept_vector), // R15
    .valid  (accept_valid)
  );

  // Helper state for the checks below
  logic first_seen;
  logic standby_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_seen <= 1'b0;
    end else begin
      first_seen <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= standby;
    end
  end

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!arst_n);

  reset_clear_a : assert property ( // R2
    !first_seen |-> (reg_value[0] == SIVR_RESET_VALUE)
                 && (reg_value[1] == SIVR_RESET_VALUE)
                 && (reg_value[2] == SIVR_RESET_VALUE)
                 && (reg_value[3] == SIVR_RESET_VALUE)
                 && (rdata == SIVR_RESET_VALUE)
                 && !accept_valid
  ) else $error("registers not clear after reset");

  reset_ports_a : assert property ( // R2
    !first_seen |-> (fifo_rx_overrun_vector == SIVR_VEC_RESET)
                 && (fifo_tx_underrun_vector == SIVR_VEC_RESET)
                 && (fifo_rx_full_vector == SIVR_VEC_RESET)
                 && (fifo_tx_empty_vector == SIVR_VEC_RESET)
                 && (unit1_rx_overrun_vector == SIVR_VEC_RESET)
                 && (unit1_tx_underrun_vector == SIVR_VEC_RESET)
                 && (unit1_rx_full_vector == SIVR_VEC_RESET)
                 && (unit1_tx_empty_vector == SIVR_VEC_RESET)
  ) else $error("vector outputs not clear after reset");

  rsvd_read_a : assert property ( // R4
    (rdata[SIVR_RSVD_HI] == 1'b0) && (rdata[SIVR_RSVD_LO] == 1'b0)
  ) else $error("reserved bit read as one");

  rsvd_store_a : assert property ( // R4
    wr |=> (reg_value[0][SIVR_RSVD_HI] == 1'b0)
        && (reg_value[1][SIVR_RSVD_LO] == 1'b0)
        && (reg_value[2][SIVR_RSVD_HI] == 1'b0)
        && (reg_value[3][SIVR_RSVD_LO] == 1'b0)
  ) else $error("reserved bit stored");

  idle_read_a : assert property ( // R1
    !rd |=> (rdata == SIVR_RESET_VALUE)
  ) else $error("read data outside the answer cycle");

  unmapped_read_a : assert property ( // R1
    (rd && (hit == '0)) |=> (rdata == SIVR_RESET_VALUE)
  ) else $error("unmapped offset read nonzero");

  standby_hold_a : assert property ( // R3
    ((standby != standby_q) && !wr) |=>
      $stable(fields)
  ) else $error("standby edge changed a vector field");

  no_write_hold_a : assert property ( // R3
    !wr [*2] |=> $stable(fields)
  ) else $error("vector field moved without a write");

  for (genvar k = 0; k < SIVR_NUM_REGS; k++) begin : g_chk
    // Upper fields give sources 0,2,4,6; lower fields 1,3,5,7
    field_write_a : assert property ( // R6 R7 R8 R9 R10 R11 R12 R13 R14
      (wr && hit[k]) |=>
        (hi_field[k] == $past(wdata[SIVR_HI_MSB:SIVR_HI_LSB]))
        && (lo_field[k] == $past(wdata[SIVR_LO_MSB:SIVR_LO_LSB]))
    ) else $error("vector field differs from written value");

    other_write_a : assert property ( // R1
      (wr && !hit[k]) |=> $stable(reg_value[k])
    ) else $error("write hit the wrong register");

    read_back_a : assert property ( // R1
      (wr && hit[k]) ##1 (rd && hit[k]) |=>
        (rdata == ($past(wdata, 2) & SIVR_WRITE_MASK))
    ) else $error("read back differs from write");

    read_value_a : assert property ( // R1
      (rd && hit[k]) |=> (rdata == $past(reg_value[k]))
    ) else $error("read data differs from register");
  end

  port_map_a : assert property ( // R7 R8
    (wr && hit[0]) |=>
      (fifo_rx_overrun_vector == $past(wdata[SIVR_HI_MSB:SIVR_HI_LSB]))
      && (fifo_tx_underrun_vector == $past(wdata[SIVR_LO_MSB:SIVR_LO_LSB]))
  ) else $error("FIFO error vector outputs differ from write");

  map_fifo_data_a : assert property ( // R9 R10
    (wr && hit[1]) |=>
      (fifo_rx_full_vector == $past(wdata[SIVR_HI_MSB:SIVR_HI_LSB]))
      && (fifo_tx_empty_vector == $past(wdata[SIVR_LO_MSB:SIVR_LO_LSB]))
  ) else $error("FIFO data vector outputs differ from write");

  map_unit1_err_a : assert property ( // R11 R12
    (wr && hit[2]) |=>
      (unit1_rx_overrun_vector == $past(wdata[SIVR_HI_MSB:SIVR_HI_LSB]))
      && (unit1_tx_underrun_vector == $past(wdata[SIVR_LO_MSB:SIVR_LO_LSB]))
  ) else $error("unit 1 error vector outputs differ from write");

  map_unit1_data_a : assert property ( // R13 R14
    (wr && hit[3]) |=>
      (unit1_rx_full_vector == $past(wdata[SIVR_HI_MSB:SIVR_HI_LSB]))
      && (unit1_tx_empty_vector == $past(wdata[SIVR_LO_MSB:SIVR_LO_LSB]))
  ) else $error("unit 1 data vector outputs differ from write");

  read_fifo_err_a : assert property ( // R1 R7 R8
    (rd && hit[0]) |=>
      (rdata == {1'b0, $past(fifo_rx_overrun_vector),
                 1'b0, $past(fifo_tx_underrun_vector)})
  ) else $error("FIFO error register read wrong");

  read_fifo_data_a : assert property ( // R1 R9 R10
    (rd && hit[1]) |=>
      (rdata == {1'b0, $past(fifo_rx_full_vector),
                 1'b0, $past(fifo_tx_empty_vector)})
  ) else $error("FIFO data register read wrong");

  read_unit1_err_a : assert property ( // R1 R11 R12
    (rd && hit[2]) |=>
      (rdata == {1'b0, $past(unit1_rx_overrun_vector),
                 1'b0, $past(unit1_tx_underrun_vector)})
  ) else $error("unit 1 error register read wrong");

  read_unit1_data_a : assert property ( // R1 R13 R14
    (rd && hit[3]) |=>
      (rdata == {1'b0, $past(unit1_rx_full_vector),
                 1'b0, $past(unit1_tx_empty_vector)})
  ) else $error("unit 1 data register read wrong");

  accept_vec_a : assert property ( // R15
    accept |=> accept_valid
            && (accept_vector == $past(
                 fields[accept_src*SIVR_VEC_W +: SIVR_VEC_W]))
  ) else $error("accepted vector is not the source field");

  accept_pulse_a : assert property ( // R15
    !accept |=> !accept_valid
  ) else $error("vector valid without acceptance");

  accept_hold_a : assert property ( // R15
    !accept |=> $stable(accept_vector)
  ) else $error("accepted vector changed while idle");

  unmapped_write_a : assert property ( // R1
    (wr && (hit == '0)) |=> $stable(fields)
  ) else $error("unmapped write moved a vector field");

  acc_fifo_rxo_a : assert property ( // R7 R15
    (accept && (accept_src == SIVR_SRC_FIFO_RX_OVERRUN)) |=>
      (accept_vector == $past(fifo_rx_overrun_vector))
  ) else $error("wrong vector for FIFO receive overrun");

  acc_fifo_txu_a : assert property ( // R8 R15
    (accept && (accept_src == SIVR_SRC_FIFO_TX_UNDERRUN)) |=>
      (accept_vector == $past(fifo_tx_underrun_vector))
  ) else $error("wrong vector for FIFO transmit underrun");

  acc_fifo_rxf_a : assert property ( // R9 R15
    (accept && (accept_src == SIVR_SRC_FIFO_RX_FULL)) |=>
      (accept_vector == $past(fifo_rx_full_vector))
  ) else $error("wrong vector for FIFO receive full");

  acc_fifo_txe_a : assert property ( // R10 R15
    (accept && (accept_src == SIVR_SRC_FIFO_TX_EMPTY)) |=>
      (accept_vector == $past(fifo_tx_empty_vector))
  ) else $error("wrong vector for FIFO transmit empty");

  acc_u1_rxo_a : assert property ( // R11 R15
    (accept && (accept_src == SIVR_SRC_U1_RX_OVERRUN)) |=>
      (accept_vector == $past(unit1_rx_overrun_vector))
  ) else $error("wrong vector for unit 1 receive overrun");

  acc_u1_txu_a : assert property ( // R12 R15
    (accept && (accept_src == SIVR_SRC_U1_TX_UNDERRUN)) |=>
      (accept_vector == $past(unit1_tx_underrun_vector))
  ) else $error("wrong vector for unit 1 transmit underrun");

  acc_u1_rxf_a : assert property ( // R13 R15
    (accept && (accept_src == SIVR_SRC_U1_RX_FULL)) |=>
      (accept_vector == $past(unit1_rx_full_vector))
  ) else $error("wrong vector for unit 1 receive full");

  acc_u1_txe_a : assert property ( // R14 R15
    (accept && (accept_src == SIVR_SRC_U1_TX_EMPTY)) |=>
      (accept_vector == $past(unit1_tx_empty_vector))
  ) else $error("wrong vector for unit 1 transmit empty");

  max_vector_c : cover property (
    (wr && (wdata[SIVR_HI_MSB:SIVR_HI_LSB] == 7'h7F)) ##1 rd
  );

  standby_cycle_c : cover property (
    $rose(standby) ##[1:20] $fell(standby)
  );

  write_read_c : cover property (
    (wr && hit[3]) ##1 (rd && hit[3])
  );

  accept_unit1_c : cover property (
    accept && (accept_src == SIVR_SRC_U1_TX_EMPTY)
  );

  accept_burst_c : cover property (
    accept ##1 accept
  );

endmodule : sivr_top
`default_nettype wire

// *** tb/tb_sivr_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_sivr_top
  import sivr_pkg::*;
;
  `define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    num_errors++; $display("wrong value t=%0t got %h exp %h", $time, \
    got, exp); end end

  logic         clk;
  logic         arst_n;
  logic         standby;
  logic [3:0]   addr;
  logic [15:0]  wdata;
  logic         wr;
  logic         rd;
  logic [15:0]  rdata;
  logic [6:0]   v [8];
  logic         accept;
  sivr_src_type accept_src;
  logic [6:0]   accept_vector;
  logic         accept_valid;
  logic [15:0]  exp_reg [4];
  logic [15:0]  qr [$];
  logic [6:0]   qa [$];
  logic [15:0]  er;
  logic [6:0]   ea;
  logic         rd_d;
  logic         acc_d;
  int           num_errors;
  int           n_compared;
  int           cycles;

  sivr_top i_dut (
    .clk(clk), .arst_n(arst_n), .standby(standby), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .fifo_rx_overrun_vector(v[0]), .fifo_tx_underrun_vector(v[1]),
    .fifo_rx_full_vector(v[2]), .fifo_tx_empty_vector(v[3]),
    .unit1_rx_overrun_vector(v[4]), .unit1_tx_underrun_vector(v[5]),
    .unit1_rx_full_vector(v[6]), .unit1_tx_empty_vector(v[7]),
    .accept(accept), .accept_src(accept_src),
    .accept_vector(accept_vector), .accept_valid(accept_valid)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic int reg_idx(input logic [3:0] a);
    for (int k = 0; k < 4; k++) if (a == SIVR_REG_OFFSET[k]) return k;
    return -1;
  endfunction : reg_idx

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1; rd <= 1'b0; accept <= 1'b0;
    // Reserved bits are dropped by the device
    if (reg_idx(a) >= 0) exp_reg[reg_idx(a)] = d & 16'h7F7F;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1; wr <= 1'b0; accept <= 1'b0;
    qr.push_back(reg_idx(a) >= 0 ? exp_reg[reg_idx(a)] : 16'h0000);
  endtask : bus_rd

  task automatic acc(input logic [2:0] s);
    @(posedge clk);
    accept <= 1'b1; accept_src <= sivr_src_type'(s);
    wr <= 1'b0; rd <= 1'b0;
    // Even source takes the upper field, odd the lower
    qa.push_back(s[0] ? exp_reg[s[2:1]][6:0] : exp_reg[s[2:1]][14:8]);
  endtask : acc

  task automatic idle(input int n);
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0; accept <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic rd_all;
    for (int k = 0; k < 4; k++) bus_rd(SIVR_REG_OFFSET[k]);
  endtask : rd_all

  task automatic chk_fields;
    idle(0);
    @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      `CHK(v[2*k], exp_reg[k][14:8])
      `CHK(v[2*k+1], exp_reg[k][6:0])
    end
  endtask : chk_fields

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Result watcher: one cycle after a read, or one cycle after each accept pulse
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_d <= 1'b0;
      acc_d <= 1'b0;
    end else begin
      rd_d <= rd;
      acc_d <= accept;
      if (rd_d && qr.size() > 0) begin
        er = qr.pop_front();
        `CHK(rdata, er)
      end else begin
        `CHK(rdata, 16'h0000)
      end
      `CHK(accept_valid, acc_d)
      if (acc_d && qa.size() > 0) begin
        ea = qa.pop_front();
        `CHK(accept_vector, ea)
      end
    end
  end

  // Whole run is under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'hD672F635));
    arst_n = 1'b0; standby = 1'b0; addr = 4'h0; wdata = 16'h0000;
    wr = 1'b0; rd = 1'b0; accept = 1'b0; accept_src = SIVR_SRC_FIFO_RX_OVERRUN;
    num_errors = 0; n_compared = 0; cycles = 0;
    for (int k = 0; k < 4; k++) exp_reg[k] = 16'h0000;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_all();
    bus_rd(4'h1);
    bus_rd(4'h8);
    for (int k = 0; k < 4; k++) bus_wr(SIVR_REG_OFFSET[k], 16'hFFFF);
    rd_all();
    chk_fields();
    for (int k = 0; k < 4; k++) begin
      bus_wr(SIVR_REG_OFFSET[k], 16'($urandom()) & 16'h7F7F);
      bus_rd(SIVR_REG_OFFSET[k]);
    end
    bus_wr(4'h1, 16'h1111);
    bus_wr(4'hE, 16'h2222);
    rd_all();
    chk_fields();
    // Contents must ride through standby entry and exit
    @(posedge clk) standby <= 1'b1;
    idle(3);
    rd_all();
    idle(0);
    standby <= 1'b0;
    rd_all();
    chk_fields();
    for (int s = 0; s < 8; s++) acc(3'(s));
    for (int s = 0; s < 8; s++) acc(3'($urandom()));
    bus_wr(SIVR_REG_OFFSET[2], 16'h8080);
    bus_rd(SIVR_REG_OFFSET[2]);
    acc(3'd2);
    acc(3'd3);
    chk_fields();
    idle(3);
    arst_n <= 1'b0;
    for (int k = 0; k < 4; k++) exp_reg[k] = 16'h0000;
    idle(1);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_all();
    chk_fields();
    idle(3);
    `CHK(qr.size() + qa.size(), 0)
    end_of_test();
  end
endmodule : tb_sivr_top
`default_nettype wire
